// ### rtl/clkctl_defs.svh
// register indices, field positions, reset values and counts of the clock controller
`ifndef CLKCTL_DEFS_SVH
`define CLKCTL_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_OSC_CTRL      16'h10e0
`define IDX_CLK_SEL_GEAR  16'h10e1
`define IDX_WARMUP_HALT   16'h10e2
`define IDX_NOISE_PROT    16'h10e3
`define IDX_KEY_FIRST     16'h10e4
`define IDX_KEY_SECOND    16'h10e5
`define IDX_PLL_SEL_STAT  16'h10e8
`define IDX_PLL_POWER     16'h10e9

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_HIGH_OSC_EN   7
`define BIT_LOW_OSC_EN    6
`define BIT_WARMUP_START  2
`define BIT_SYS_CLK_SEL   3
`define BIT_GEAR_LSB      0
`define BIT_WARMUP_LSB    4
`define BIT_HALT_LSB      2
`define BIT_DRVE          0
`define BIT_PROTECT       7
`define BIT_HIGH_DRIVE    1
`define BIT_LOW_DRIVE     0
`define BIT_PLL_SRC       6
`define BIT_LOCKUP_DONE   5
`define BIT_PLL_ON        7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_HIGH_OSC_EN   1'b1
`define RST_LOW_OSC_EN    1'b1
`define RST_SYS_CLK_SEL   1'b0
`define RST_GEAR          3'h4
`define RST_WARMUP_SEL    2'h2
`define RST_HALT_MODE     2'h3
`define RST_DRVE          1'b0
`define RST_HIGH_DRIVE    1'b1
`define RST_LOW_DRIVE     1'b1
`define RST_PLL_SRC       1'b0
`define RST_PLL_ON        1'b0

// ----------------------------------------------------------------------------
// gear and timer counts
// ----------------------------------------------------------------------------
`define GEAR_MAX          3'h4
`define WARMUP_EXP_SHORT  5'd8
`define WARMUP_EXP_MID    5'd14
`define WARMUP_EXP_LONG   5'd16
`define LOCKUP_STAGES     16

`endif

// ### rtl/clkctl_pkg.sv
// types shared by the clock controller modules
package clkctl_pkg;

  // --------------------------------------------------------------------------
  // configuration held in the control registers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       high_osc_enable;
    logic       low_osc_enable;
    logic       system_clock_select;
    logic [2:0] gear_divider_field;
    logic [1:0] warmup_duration_select;
    logic [1:0] halt_mode;
    logic       drive_in_stop;
    logic       high_osc_drive;
    logic       low_osc_drive;
    logic       pll_source_select;
    logic       pll_power_on;
  } clk_cfg_s;

  // --------------------------------------------------------------------------
  // protection key sequence
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    KEY_IDLE,
    KEY_ARMED
  } key_state_e;

  // terminal count of the gear divider for a gear code
  function automatic logic [3:0] gear_limit(input logic [2:0] gear);
    logic [3:0] lim;
    lim = 4'h0;
    unique case (gear)
      3'h0:    lim = 4'h0;
      3'h1:    lim = 4'h1;
      3'h2:    lim = 4'h3;
      3'h3:    lim = 4'h7;
      default: lim = 4'hf;
    endcase
    return lim;
  endfunction

endpackage

// ### rtl/clock_gear_divider.sv
// clock gear divider and system clock selection, as tick pulses
`timescale 1ns/1ps
`default_nettype none
`include "clkctl_defs.svh"

module clock_gear_divider (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       fc_tick,
  input  wire logic       low_tick,
  input  wire logic [2:0] gear_req,
  input  wire logic       low_sel,
  output logic            geared_tick,
  output logic            sys_tick,
  output logic [2:0]      gear_active
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [2:0] gear_q;
  logic [2:0] gear_d;
  logic       half_q;
  logic       half_d;
  logic       gtick_q;
  logic       gtick_d;
  logic       stick_q;
  logic       stick_d;

  // --------------------------------------------------------------------------
  // divider; a new gear is taken only at the end of a divided period
  // --------------------------------------------------------------------------
  always_comb begin
    cnt_d   = cnt_q;
    gear_d  = gear_q;
    half_d  = half_q;
    gtick_d = 1'b0;
    if (fc_tick) begin
      if (cnt_q >= clkctl_pkg::gear_limit(gear_q)) begin
        cnt_d   = 4'h0;
        gtick_d = 1'b1;
        half_d  = ~half_q;
        if (gear_req <= `GEAR_MAX) begin
          gear_d = gear_req;
        end
      end else begin
        cnt_d = 4'(cnt_q + 4'h1);
      end
    end
    stick_d = low_sel ? low_tick : (gtick_d & half_q);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= 4'h0;
      gear_q  <= `RST_GEAR;
      half_q  <= 1'b0;
      gtick_q <= 1'b0;
      stick_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      gear_q  <= gear_d;
      half_q  <= half_d;
      gtick_q <= gtick_d;
      stick_q <= stick_d;
    end
  end

  assign geared_tick = gtick_q;
  assign sys_tick    = stick_q;
  assign gear_active = gear_q;

endmodule
`default_nettype wire

// ### rtl/osc_warmup_timer.sv
// warm-up timer counting ticks of the oscillator being started
`timescale 1ns/1ps
`default_nettype none
`include "clkctl_defs.svh"

module osc_warmup_timer (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       osc_tick,
  input  wire logic [1:0] dur_sel,
  output logic            busy
);

  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic        busy_q;
  logic        busy_d;
  logic [4:0]  exp_sel;
  logic [16:0] last;

  // --------------------------------------------------------------------------
  // duration and counting
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (dur_sel)
      2'h2:    exp_sel = `WARMUP_EXP_MID;
      2'h3:    exp_sel = `WARMUP_EXP_LONG;
      default: exp_sel = `WARMUP_EXP_SHORT;
    endcase
    last   = 17'((17'h1 << exp_sel) - 17'h1);
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (start) begin
      cnt_d  = 17'h0;
      busy_d = 1'b1;
    end else if (busy_q && osc_tick) begin
      if (cnt_q == last) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = 17'(cnt_q + 17'h1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= 17'h0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;

endmodule
`default_nettype wire

// ### rtl/system_clock_pll_controller.sv
// system clock controller with gear, warm-up timer, pll and write protection
//
// Overview of operation
// - system clock from geared high or low clock
// - oscillator enable bits 7 and 6 independent
// - gear divides high clock by 1..16
// - gear codes 000..100; 101, 110 reserved
// - reset: high oscillator, high path, gear /16
// - low oscillator runs after reset
// - warm-up code selects 2^8, 2^14, 2^16 ticks
// - warm-up counts the started oscillator's ticks
// - bit 2 write starts timer; poll until zero
// - new gear applies after a delay
// - unassigned bits read undefined (zero here)
// - protection blocks clock, noise and pll writes
// - low drive resets to normal, zero is weak
// - lock-up flag bit 5 reads one when done
// - pll enable starts 16-stage lock-up counter
`timescale 1ns/1ps
`default_nettype none
`include "clkctl_defs.svh"

module system_clock_pll_controller #(
  parameter logic [7:0] KEY_FIRST_VAL  = 8'h5a, // arbitrary key value
  parameter logic [7:0] KEY_SECOND_VAL = 8'ha5, // arbitrary key value
  parameter int         LOCKUP_BITS    = `LOCKUP_STAGES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        high_osc_tick,
  input  wire logic        low_osc_tick,
  input  wire logic        pll_tick,
  output logic             high_osc_enable,
  output logic             low_osc_enable,
  output logic             high_osc_drive,
  output logic             low_osc_drive,
  output logic             pll_power_on,
  output logic             geared_clock,
  output logic             sys_clock_tick,
  output logic             protect_on,
  output logic [1:0]       halt_mode
);

  // --------------------------------------------------------------------------
  // bus data phase capture
  // --------------------------------------------------------------------------
  logic        wr_q;
  logic        wr_d;
  logic [15:0] idx_q;
  logic [15:0] idx_d;
  logic        hit;

  always_comb begin
    hit   = (haddr[31:18] == 14'h0) && (haddr[1:0] == 2'h0);
    wr_d  = 1'b0;
    idx_d = idx_q;
    if (hsel && htrans[1] && hready) begin
      wr_d  = hwrite && hit;
      idx_d = hit ? haddr[17:2] : 16'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q  <= 1'b0;
      idx_q <= 16'h0;
    end else begin
      wr_q  <= wr_d;
      idx_q <= idx_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------------
  // control registers and protection
  // --------------------------------------------------------------------------
  clkctl_pkg::clk_cfg_s   cfg_q;
  clkctl_pkg::clk_cfg_s   cfg_d;
  clkctl_pkg::key_state_e key_q;
  clkctl_pkg::key_state_e key_d;
  logic                   prot_q;
  logic                   prot_d;
  logic                   wu_start;
  logic [7:0]             wb;
  logic                   wr_ok;

  always_comb begin
    wb       = hwdata[7:0];
    cfg_d    = cfg_q;
    key_d    = key_q;
    prot_d   = prot_q;
    wu_start = 1'b0;
    wr_ok    = wr_q && !prot_q;
    if (wr_q) begin
      key_d = clkctl_pkg::KEY_IDLE;
      if (idx_q == `IDX_KEY_FIRST && wb == KEY_FIRST_VAL) begin
        key_d = clkctl_pkg::KEY_ARMED;
      end
      if (idx_q == `IDX_KEY_SECOND && wb == KEY_SECOND_VAL
          && key_q == clkctl_pkg::KEY_ARMED) begin
        prot_d = ~prot_q;
      end
    end
    if (wr_ok) begin
      unique case (idx_q)
        `IDX_OSC_CTRL: begin
          cfg_d.high_osc_enable = wb[`BIT_HIGH_OSC_EN];
          cfg_d.low_osc_enable  = wb[`BIT_LOW_OSC_EN];
          wu_start              = wb[`BIT_WARMUP_START];
        end
        `IDX_CLK_SEL_GEAR: begin
          cfg_d.system_clock_select = wb[`BIT_SYS_CLK_SEL];
          cfg_d.gear_divider_field  = wb[`BIT_GEAR_LSB +: 3];
        end
        `IDX_WARMUP_HALT: begin
          cfg_d.warmup_duration_select = wb[`BIT_WARMUP_LSB +: 2];
          cfg_d.halt_mode              = wb[`BIT_HALT_LSB +: 2];
          cfg_d.drive_in_stop          = wb[`BIT_DRVE];
        end
        `IDX_NOISE_PROT: begin
          cfg_d.high_osc_drive = wb[`BIT_HIGH_DRIVE];
          cfg_d.low_osc_drive  = wb[`BIT_LOW_DRIVE];
        end
        `IDX_PLL_SEL_STAT: begin
          cfg_d.pll_source_select = wb[`BIT_PLL_SRC];
        end
        `IDX_PLL_POWER: begin
          cfg_d.pll_power_on = wb[`BIT_PLL_ON];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q.high_osc_enable        <= `RST_HIGH_OSC_EN;
      cfg_q.low_osc_enable         <= `RST_LOW_OSC_EN;
      cfg_q.system_clock_select    <= `RST_SYS_CLK_SEL;
      cfg_q.gear_divider_field     <= `RST_GEAR;
      cfg_q.warmup_duration_select <= `RST_WARMUP_SEL;
      cfg_q.halt_mode              <= `RST_HALT_MODE;
      cfg_q.drive_in_stop          <= `RST_DRVE;
      cfg_q.high_osc_drive         <= `RST_HIGH_DRIVE;
      cfg_q.low_osc_drive          <= `RST_LOW_DRIVE;
      cfg_q.pll_source_select      <= `RST_PLL_SRC;
      cfg_q.pll_power_on           <= `RST_PLL_ON;
      key_q                        <= clkctl_pkg::KEY_IDLE;
      prot_q                       <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      key_q  <= key_d;
      prot_q <= prot_d;
    end
  end

  // --------------------------------------------------------------------------
  // pll lock-up counter
  // --------------------------------------------------------------------------
  logic [LOCKUP_BITS-1:0] lock_cnt_q;
  logic [LOCKUP_BITS-1:0] lock_cnt_d;
  logic                   lock_done_q;
  logic                   lock_done_d;

  always_comb begin
    lock_cnt_d  = lock_cnt_q;
    lock_done_d = lock_done_q;
    if (!cfg_q.pll_power_on) begin
      lock_cnt_d  = '0;
      lock_done_d = 1'b0;
    end else if (!lock_done_q && high_osc_tick) begin
      lock_cnt_d = lock_cnt_q + 1'b1;
      if (&lock_cnt_q) begin
        lock_done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_cnt_q  <= '0;
      lock_done_q <= 1'b0;
    end else begin
      lock_cnt_q  <= lock_cnt_d;
      lock_done_q <= lock_done_d;
    end
  end

  // --------------------------------------------------------------------------
  // warm-up timer and gear
  // --------------------------------------------------------------------------
  logic       wu_busy;
  logic       wu_tick;
  logic       fc_tick;
  logic [2:0] gear_now;

  // the started oscillator is the one not feeding the system clock
  assign wu_tick = cfg_q.system_clock_select ? high_osc_tick : low_osc_tick;
  assign fc_tick = (cfg_q.pll_source_select && cfg_q.pll_power_on)
                   ? pll_tick : high_osc_tick;

  osc_warmup_timer u_warmup (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (wu_start),
    .osc_tick (wu_tick),
    .dur_sel  (cfg_q.warmup_duration_select),
    .busy     (wu_busy)
  );

  clock_gear_divider u_gear (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .fc_tick     (fc_tick),
    .low_tick    (low_osc_tick),
    .gear_req    (cfg_q.gear_divider_field),
    .low_sel     (cfg_q.system_clock_select),
    .geared_tick (geared_clock),
    .sys_tick    (sys_clock_tick),
    .gear_active (gear_now)
  );

  // --------------------------------------------------------------------------
  // read data; unassigned bits read zero
  // --------------------------------------------------------------------------
  logic [7:0] rb;

  always_comb begin
    rb = 8'h0;
    unique case (idx_q)
      `IDX_OSC_CTRL: begin
        rb[`BIT_HIGH_OSC_EN]  = cfg_q.high_osc_enable;
        rb[`BIT_LOW_OSC_EN]   = cfg_q.low_osc_enable;
        rb[`BIT_WARMUP_START] = wu_busy;
      end
      `IDX_CLK_SEL_GEAR: begin
        rb[`BIT_SYS_CLK_SEL]     = cfg_q.system_clock_select;
        rb[`BIT_GEAR_LSB +: 3]   = cfg_q.gear_divider_field;
      end
      `IDX_WARMUP_HALT: begin
        rb[`BIT_WARMUP_LSB +: 2] = cfg_q.warmup_duration_select;
        rb[`BIT_HALT_LSB +: 2]   = cfg_q.halt_mode;
        rb[`BIT_DRVE]            = cfg_q.drive_in_stop;
      end
      `IDX_NOISE_PROT: begin
        rb[`BIT_PROTECT]    = prot_q;
        rb[`BIT_HIGH_DRIVE] = cfg_q.high_osc_drive;
        rb[`BIT_LOW_DRIVE]  = cfg_q.low_osc_drive;
      end
      `IDX_PLL_SEL_STAT: begin
        rb[`BIT_PLL_SRC]     = cfg_q.pll_source_select;
        rb[`BIT_LOCKUP_DONE] = lock_done_q;
      end
      `IDX_PLL_POWER: begin
        rb[`BIT_PLL_ON] = cfg_q.pll_power_on;
      end
      default: begin
      end
    endcase
    hrdata = {24'h0, rb};
  end

  assign high_osc_enable = cfg_q.high_osc_enable;
  assign low_osc_enable  = cfg_q.low_osc_enable;
  assign high_osc_drive  = cfg_q.high_osc_drive;
  assign low_osc_drive   = cfg_q.low_osc_drive;
  assign pll_power_on    = cfg_q.pll_power_on;
  assign protect_on      = prot_q;
  assign halt_mode       = cfg_q.halt_mode;

endmodule
`default_nettype wire

// ### sim/system_clock_pll_controller_sva.sv
// assertion checker for the clock controller bus and control outputs
`timescale 1ns/1ps
`default_nettype none
`include "clkctl_defs.svh"

module system_clock_pll_controller_sva #(
  parameter logic [7:0] KEY_SECOND_VAL = 8'ha5
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        high_osc_enable,
  input wire logic        low_osc_enable,
  input wire logic        high_osc_drive,
  input wire logic        low_osc_drive,
  input wire logic        pll_power_on,
  input wire logic        protect_on,
  input wire logic [1:0]  halt_mode
);
  // ---------------------------------------------------------------
  // data phase tracking
  // ---------------------------------------------------------------
  logic        take, wr_d, wr_q, rd_d, rd_q, key2_hit;
  logic [15:0] idx_d, idx_q;
  logic [4:0]  lv;
  assign lv = {high_osc_enable, low_osc_enable, high_osc_drive, low_osc_drive, pll_power_on};
  assign key2_hit = wr_q && idx_q == `IDX_KEY_SECOND && hwdata[7:0] == KEY_SECOND_VAL;
  always_comb begin
    take = hsel && htrans[1] && hready && haddr[31:18] == 14'h0 && haddr[1:0] == 2'h0;
    wr_d = take && hwrite;
    rd_d = take && !hwrite;
    idx_d = take ? haddr[17:2] : idx_q;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 16'h0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      idx_q <= idx_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  reset_levels_a: assert property (
    $fell(sys_rst) |-> high_osc_enable && low_osc_enable && high_osc_drive
      && low_osc_drive && !pll_power_on && !protect_on)
    else $error("levels wrong after reset");
  osc_wr_a: assert property (
    wr_q && !protect_on && idx_q == `IDX_OSC_CTRL |=>
      {high_osc_enable, low_osc_enable} == $past(hwdata[7:6]))
    else $error("oscillator enables not written");
  drive_wr_a: assert property (
    wr_q && !protect_on && idx_q == `IDX_NOISE_PROT |=>
      {high_osc_drive, low_osc_drive} == $past(hwdata[1:0]))
    else $error("drive bits not written");
  pll_wr_a: assert property (
    wr_q && !protect_on && idx_q == `IDX_PLL_POWER |=> pll_power_on == $past(hwdata[7]))
    else $error("pll power not written");
  halt_wr_a: assert property (
    wr_q && !protect_on && idx_q == `IDX_WARMUP_HALT |=> halt_mode == $past(hwdata[3:2]))
    else $error("halt mode not written");
  protect_block_a: assert property (
    wr_q && protect_on && idx_q inside {`IDX_OSC_CTRL, `IDX_NOISE_PROT, `IDX_PLL_POWER}
      |=> $stable(lv))
    else $error("protected write took effect");
  protect_toggle_a: assert property (
    $changed(protect_on) |-> $past(key2_hit))
    else $error("protection changed without second key");
  unassigned_zero_a: assert property (
    rd_q && idx_q == `IDX_OSC_CTRL |-> hrdata[31:8] == 24'h0 && hrdata[5:3] == 3'h0
      && hrdata[1:0] == 2'h0)
    else $error("unassigned bits not zero");
endmodule
`default_nettype wire

// ### sim/system_clock_pll_controller_tb.sv
// self-checking bench for the clock controller
`timescale 1ns/1ps
`default_nettype none
`include "clkctl_defs.svh"

module system_clock_pll_controller_tb;
  localparam logic [7:0] K1 = 8'h5a; // arbitrary key value
  localparam logic [7:0] K2 = 8'ha5; // arbitrary key value
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, halt_mode;
  logic [2:0]  hsize;
  logic [7:0]  rv;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  logic        hot, lot, pt, hoe, loe, hod, lod, ppo, gck, sck, pro;
  wire logic   hready;
  integer      seed = 32'h0c91;
  int          error_cnt = 0, n_tests = 0, lcnt = 0, cyc = 0;
  assign hready = hreadyout;

  system_clock_pll_controller #(.KEY_FIRST_VAL(K1), .KEY_SECOND_VAL(K2), .LOCKUP_BITS(4))
    system_clock_pll_controller_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .high_osc_tick(hot), .low_osc_tick(lot),
    .pll_tick(pt), .high_osc_enable(hoe), .low_osc_enable(loe), .high_osc_drive(hod),
    .low_osc_drive(lod), .pll_power_on(ppo), .geared_clock(gck), .sys_clock_tick(sck),
    .protect_on(pro), .halt_mode(halt_mode));

  // ---------------------------------------------------------------
  // clock, oscillator ticks and read monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hot = 1'b0;
    lot = 1'b0;
    pt = 1'b0;
    rd_dp = 1'b0;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hot <= cyc % 4 == 0;
    pt <= 1'b1;
    lot <= ($random(seed) & 7) == 0;
    if (lot) lcnt <= lcnt + 1;
  end
  always @(posedge clk) begin
    if (rd_dp && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp(hrdata & {24'hffffff, e[15:8]}, {24'h0, e[15:8] & e[7:0]});
    end
    rd_dp <= htrans == 2'h2 && !hwrite && hready;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    cmp(32'(got >= exp - 2 && got <= exp + 2), 32'h1);
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    hwrite <= w;
    htrans <= 2'h2;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'($random(seed)), d};
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata[7:0];
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] ev, input logic [7:0] m = 8'hff);
    exp_q.push_back({m, ev});
    xfer(1'b0, idx, 8'h0);
  endtask
  task automatic meas(input int n, output int g, output int s);
    g = 0;
    s = 0;
    repeat (n) begin
      @(posedge clk);
      if (gck === 1'b1) g++;
      if (sck === 1'b1) s++;
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    int g, s, l0, d;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`IDX_OSC_CTRL, 8'hc0);
    rd(`IDX_CLK_SEL_GEAR, 8'h04);
    rd(`IDX_WARMUP_HALT, 8'h2c);
    rd(`IDX_NOISE_PROT, 8'h03);
    rd(`IDX_PLL_SEL_STAT, 8'h00);
    rd(`IDX_PLL_POWER, 8'h00);
    wr(16'h10e6, 8'hff);
    rd(16'h10e6, 8'h00);
    $display("reset values done");
    meas(512, g, s);
    near(g, 8);
    near(s, 4);
    for (int k = 0; k <= 5; k++) begin
      wr(`IDX_CLK_SEL_GEAR, 8'(k));
      wr(16'h10e6, 8'h00);
      repeat (80) @(posedge clk);
      meas(512, g, s);
      d = k > 4 ? 4 : k;
      near(g, 128 >> d);
      near(s, 64 >> d);
    end
    wr(`IDX_CLK_SEL_GEAR, 8'h08);
    repeat (4) @(posedge clk);
    l0 = lcnt;
    meas(512, g, s);
    near(s, lcnt - l0);
    wr(`IDX_CLK_SEL_GEAR, 8'h00);
    $display("gear and select done");
    wr(`IDX_WARMUP_HALT, 8'h1c);
    @(posedge clk) cmp(32'(halt_mode), 32'h3);
    wr(`IDX_OSC_CTRL, 8'hc4);
    l0 = lcnt;
    rd(`IDX_OSC_CTRL, 8'h04, 8'h04);
    do rd(`IDX_OSC_CTRL, 8'h00, 8'h00); while (rv[2] !== 1'b0);
    near(lcnt - l0, 256);
    wr(`IDX_CLK_SEL_GEAR, 8'h08);
    wr(`IDX_OSC_CTRL, 8'h40);
    @(posedge clk) cmp(32'({hoe, loe}), 32'h1);
    wr(`IDX_NOISE_PROT, 8'h03);
    wr(`IDX_OSC_CTRL, 8'hc4);
    l0 = cyc;
    do rd(`IDX_OSC_CTRL, 8'h00, 8'h00); while (rv[2] !== 1'b0);
    near((cyc - l0) / 4, 256);
    wr(`IDX_CLK_SEL_GEAR, 8'h00);
    wr(`IDX_OSC_CTRL, 8'h80);
    @(posedge clk) cmp(32'({hoe, loe}), 32'h2);
    wr(`IDX_NOISE_PROT, 8'h03);
    wr(`IDX_OSC_CTRL, 8'hc0);
    $display("warm-up and switching done");
    wr(`IDX_NOISE_PROT, 8'h02);
    @(posedge clk) cmp(32'({hod, lod}), 32'h2);
    rd(`IDX_NOISE_PROT, 8'h02);
    wr(`IDX_NOISE_PROT, 8'h03);
    $display("enables and drive done");
    wr(`IDX_KEY_FIRST, K1);
    wr(`IDX_KEY_SECOND, K2);
    rd(`IDX_NOISE_PROT, 8'h83);
    @(posedge clk) cmp(32'(pro), 32'h1);
    wr(`IDX_OSC_CTRL, 8'h00);
    wr(`IDX_PLL_POWER, 8'h80);
    rd(`IDX_OSC_CTRL, 8'hc0);
    rd(`IDX_PLL_POWER, 8'h00);
    wr(`IDX_KEY_FIRST, K1);
    wr(16'h10e6, 8'h00);
    wr(`IDX_KEY_SECOND, K2);
    rd(`IDX_NOISE_PROT, 8'h83);
    wr(`IDX_KEY_FIRST, K1);
    wr(`IDX_KEY_SECOND, K2);
    rd(`IDX_NOISE_PROT, 8'h03);
    @(posedge clk) cmp(32'(pro), 32'h0);
    $display("protection done");
    wr(`IDX_PLL_POWER, 8'h80);
    @(posedge clk) cmp(32'(ppo), 32'h1);
    rd(`IDX_PLL_SEL_STAT, 8'h00);
    repeat (48) @(posedge clk);
    rd(`IDX_PLL_SEL_STAT, 8'h00, 8'h20);
    repeat (32) @(posedge clk);
    rd(`IDX_PLL_SEL_STAT, 8'h20);
    wr(`IDX_PLL_SEL_STAT, 8'h40);
    repeat (80) @(posedge clk);
    meas(512, g, s);
    near(g, 512);
    wr(`IDX_PLL_SEL_STAT, 8'h00);
    wr(`IDX_PLL_POWER, 8'h00);
    rd(`IDX_PLL_SEL_STAT, 8'h00);
    $display("pll done");
    stop_test;
  end
endmodule

bind system_clock_pll_controller system_clock_pll_controller_sva #(
  .KEY_SECOND_VAL(KEY_SECOND_VAL)) sva_inst (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .high_osc_enable(high_osc_enable),
  .low_osc_enable(low_osc_enable), .high_osc_drive(high_osc_drive),
  .low_osc_drive(low_osc_drive), .pll_power_on(pll_power_on), .protect_on(protect_on),
  .halt_mode(halt_mode));
`default_nettype wire
